// ==== dpsf_pkg.sv ====
package dpsf_pkg;

  // --------------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------------
  localparam int FLAG_COUNT    = 8;
  localparam int IDX_W         = 3;
  localparam int DATA_W        = 8;
  localparam int CNT_W         = 4;

  // --------------------------------------------------------------------------
  // Timing in nanoseconds and derived cycle counts
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SETUP_NS    = 100;
  localparam int T_WR_PULSE_NS = 200;
  localparam int T_HOLD_NS     = 100;
  localparam int T_RD_NS       = 600;
  localparam int T_GAP_NS      = 100;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_up(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam logic [CNT_W-1:0] CNT_SETUP = CNT_W'(cyc_up(T_SETUP_NS) - 1);
  localparam logic [CNT_W-1:0] CNT_WR    = CNT_W'(cyc_up(T_WR_PULSE_NS) - 1);
  localparam logic [CNT_W-1:0] CNT_HOLD  = CNT_W'(cyc_up(T_HOLD_NS) - 1);
  localparam logic [CNT_W-1:0] CNT_RD    = CNT_W'(cyc_up(T_RD_NS) - 1);
  localparam logic [CNT_W-1:0] CNT_GAP   = CNT_W'(cyc_up(T_GAP_NS) - 1);

  // --------------------------------------------------------------------------
  // Commands and flag values
  // --------------------------------------------------------------------------
  localparam logic [1:0] OP_CLAIM   = 2'h0;
  localparam logic [1:0] OP_RELEASE = 2'h1;
  localparam logic [1:0] OP_POLL    = 2'h2;
  localparam logic [1:0] OP_INIT    = 2'h3;

  localparam logic [IDX_W-1:0]  LAST_IDX   = 3'h7;
  localparam logic [DATA_W-1:0] RD_ALL_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RD_ALL_ONE  = 8'hFF;
  localparam logic [CNT_W-1:0]  INIT_WRITES = 4'h8;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_INIT   = 7'h01,
    ST_IDLE   = 7'h02,
    ST_WSETUP = 7'h04,
    ST_WPULSE = 7'h08,
    ST_WHOLD  = 7'h10,
    ST_READ   = 7'h20,
    ST_GAP    = 7'h40
  } dpsf_state_e;

endpackage : dpsf_pkg

// ==== dpsf_pin_sync.sv ====
`timescale 1ns/1ps
module dpsf_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Asynchronous pin side
  input  wire logic [W-1:0] din,
  // Synchronous side
  output logic      [W-1:0] dout
);

  // --------------------------------------------------------------------------
  // Three stages per bit; a change counts once stages two and three agree
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        s1_r    <= 1'b0;
        s2_r    <= 1'b0;
        s3_r    <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1_r <= din[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          dout[i] <= s3_r;
        end
      end
    end
  end

endmodule : dpsf_pin_sync

// ==== dpsf_host.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Write zero requests, write one releases.
// - Poller deasserts select or enable between reads.
// - Claim writes zero first, then reads back.
// - After failure keep polling or write one.
// - Software writes one to every flag initially.
// - Memory chip enable held high for flags.
module dpsf_host
  import dpsf_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Command port
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic [1:0]            cmd_op,
  input  wire logic [IDX_W-1:0]      cmd_flag,
  // Response port
  output logic                       rsp_valid,
  output logic                       rsp_granted,
  output logic                       rsp_mixed,
  output logic      [IDX_W-1:0]      rsp_flag,
  // Status
  output logic                       init_done,
  output logic      [FLAG_COUNT-1:0] owned,
  output logic      [FLAG_COUNT-1:0] pending,
  // Device pins
  output logic                       token_space_select_n,
  output logic                       mem_chip_enable_n,
  output logic                       rw_n,
  output logic                       oe_n,
  output logic      [IDX_W-1:0]      flag_index_lines,
  output logic      [DATA_W-1:0]     data_o,
  output logic                       data_oe,
  input  wire logic [DATA_W-1:0]     data_i
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  dpsf_state_e      state_r;
  dpsf_state_e      state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [1:0]       op_r;
  logic [IDX_W-1:0] flag_r;
  logic             wval_r;
  logic             need_read_r;
  logic             retry_r;
  logic             init_run_r;
  logic [IDX_W-1:0] init_idx_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] data_sync;
  logic [FLAG_COUNT-1:0] owned_r;
  logic [FLAG_COUNT-1:0] pending_r;
  logic             rsp_valid_r;
  logic             rsp_granted_r;
  logic             rsp_mixed_r;
  logic [IDX_W-1:0] rsp_flag_r;
  logic             sel_n_r;
  logic             rw_n_r;
  logic             oe_n_r;
  logic             data_oe_r;
  logic             cmd_fire;
  logic             gap_end;
  logic             resp_evt;
  logic             rd_zero;
  logic             rd_mixed;

  assign cmd_ready = (state_r == ST_IDLE) && !init_run_r;
  assign cmd_fire  = cmd_valid && cmd_ready;
  assign gap_end   = (state_r == ST_GAP) && (cnt_r == '0);
  assign resp_evt  = gap_end && !init_run_r && !need_read_r;
  assign rd_zero   = (rd_data_r == RD_ALL_ZERO);
  assign rd_mixed  = !rd_zero && (rd_data_r != RD_ALL_ONE);

  // --------------------------------------------------------------------------
  // Read data synchroniser
  // --------------------------------------------------------------------------
  dpsf_pin_sync #(
    .W    (DATA_W)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (data_i),
    .dout (data_sync)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    unique case (state_r)
      ST_INIT: begin
        state_nxt = ST_WSETUP;
        cnt_nxt   = CNT_SETUP;
      end
      ST_IDLE: begin
        if (cmd_fire) begin
          if (cmd_op == OP_INIT) begin
            state_nxt = ST_INIT;
          end else if (cmd_op == OP_POLL || (cmd_op == OP_CLAIM && pending_r[cmd_flag])) begin
            state_nxt = ST_READ;
            cnt_nxt   = CNT_RD;
          end else begin
            state_nxt = ST_WSETUP;
            cnt_nxt   = CNT_SETUP;
          end
        end
      end
      ST_WSETUP: begin
        if (cnt_r == '0) begin
          state_nxt = ST_WPULSE;
          cnt_nxt   = CNT_WR;
        end
      end
      ST_WPULSE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_WHOLD;
          cnt_nxt   = CNT_HOLD;
        end
      end
      ST_WHOLD, ST_READ: begin
        if (cnt_r == '0) begin
          state_nxt = ST_GAP;
          cnt_nxt   = CNT_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_r == '0) begin
          if (init_run_r) begin
            state_nxt = (init_idx_r == LAST_IDX) ? ST_IDLE : ST_INIT;
          end else if (need_read_r) begin
            state_nxt = ST_READ;
            cnt_nxt   = CNT_RD;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_INIT;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Access context and initialisation walk
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_r        <= OP_INIT;
      flag_r      <= '0;
      wval_r      <= 1'b1;
      need_read_r <= 1'b0;
      retry_r     <= 1'b0;
      init_run_r  <= 1'b1;
      init_idx_r  <= '0;
    end else begin
      if (cmd_fire) begin
        op_r        <= cmd_op;
        flag_r      <= cmd_flag;
        wval_r      <= (cmd_op != OP_CLAIM);
        need_read_r <= (cmd_op == OP_CLAIM) && !pending_r[cmd_flag];
        retry_r     <= (cmd_op == OP_CLAIM) && pending_r[cmd_flag];
        if (cmd_op == OP_INIT) begin
          init_run_r <= 1'b1;
          init_idx_r <= '0;
        end
      end
      if (state_r == ST_INIT) begin
        flag_r <= init_idx_r;
        wval_r <= 1'b1;
      end
      if (gap_end && init_run_r) begin
        init_idx_r <= init_idx_r + 1'b1;
        if (init_idx_r == LAST_IDX) begin
          init_run_r <= 1'b0;
        end
      end
      if (gap_end && !init_run_r && need_read_r) begin
        need_read_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read capture, ownership book-keeping and response
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r     <= RD_ALL_ONE;
      owned_r       <= '0;
      pending_r     <= '0;
      rsp_valid_r   <= 1'b0;
      rsp_granted_r <= 1'b0;
      rsp_mixed_r   <= 1'b0;
      rsp_flag_r    <= '0;
    end else begin
      rsp_valid_r <= resp_evt;
      if (state_r == ST_READ && cnt_r == '0) begin
        rd_data_r <= data_sync;
      end
      if (cmd_fire && cmd_op == OP_INIT) begin
        owned_r   <= '0;
        pending_r <= '0;
      end
      if (resp_evt) begin
        rsp_flag_r    <= flag_r;
        rsp_granted_r <= (op_r != OP_RELEASE) && rd_zero;
        rsp_mixed_r   <= (op_r != OP_RELEASE) && rd_mixed;
        if (op_r == OP_RELEASE) begin
          owned_r[flag_r]   <= 1'b0;
          pending_r[flag_r] <= 1'b0;
        end else if (rd_zero) begin
          owned_r[flag_r]   <= 1'b1;
          pending_r[flag_r] <= 1'b0;
        end else if (op_r == OP_CLAIM) begin
          pending_r[flag_r] <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_n_r   <= 1'b1;
      rw_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      data_oe_r <= 1'b0;
    end else begin
      sel_n_r   <= !(state_nxt inside {ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_READ});
      rw_n_r    <= (state_nxt != ST_WPULSE);
      oe_n_r    <= (state_nxt != ST_READ);
      data_oe_r <= (state_nxt inside {ST_WPULSE, ST_WHOLD});
    end
  end

  assign mem_chip_enable_n    = 1'b1;
  assign token_space_select_n = sel_n_r;
  assign rw_n                 = rw_n_r;
  assign oe_n                 = oe_n_r;
  assign data_oe              = data_oe_r;
  assign flag_index_lines     = flag_r;
  assign data_o               = {{(DATA_W-1){1'b0}}, wval_r};
  assign rsp_valid            = rsp_valid_r;
  assign rsp_granted          = rsp_granted_r;
  assign rsp_mixed            = rsp_mixed_r;
  assign rsp_flag             = rsp_flag_r;
  assign init_done            = !init_run_r;
  assign owned                = owned_r;
  assign pending              = pending_r;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic             claim_wrote_r;
  logic [CNT_W-1:0] init_wr_cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      claim_wrote_r <= 1'b0;
      init_wr_cnt_r <= '0;
    end else begin
      if (cmd_fire) begin
        claim_wrote_r <= 1'b0;
      end else if (!rw_n_r) begin
        claim_wrote_r <= 1'b1;
      end
      if (cmd_fire && cmd_op == OP_INIT) begin
        init_wr_cnt_r <= '0;
      end else if (init_run_r && state_r == ST_WSETUP && state_nxt == ST_WPULSE) begin
        init_wr_cnt_r <= init_wr_cnt_r + 1'b1;
      end
    end
  end

  a_ce_held_high: assert property (@(posedge clk) disable iff (!nrst) mem_chip_enable_n)
    else $error("memory chip enable driven low");
  a_read_gap_before: assert property (@(posedge clk) disable iff (!nrst) $fell(oe_n) |-> $past(token_space_select_n))
    else $error("read started without a deselect gap");
  a_claim_writes_first: assert property (@(posedge clk) disable iff (!nrst) $fell(oe_n) && op_r == OP_CLAIM && !retry_r |-> claim_wrote_r)
    else $error("claim read before its write");
  a_write_bit_zero: assert property (@(posedge clk) disable iff (!nrst) !rw_n |-> data_oe && data_o[0] == wval_r && data_o[DATA_W-1:1] == '0)
    else $error("write data not on bit zero");
  a_no_bus_fight: assert property (@(posedge clk) disable iff (!nrst) !oe_n |-> !data_oe && rw_n && !token_space_select_n)
    else $error("read overlaps a driven bus");
  a_index_stable: assert property (@(posedge clk) disable iff (!nrst) !token_space_select_n && $past(!token_space_select_n) |-> $stable(flag_index_lines))
    else $error("flag index moved during access");
  a_write_pulse_len: assert property (@(posedge clk) disable iff (!nrst) $fell(rw_n) |-> !rw_n [*2] ##1 rw_n)
    else $error("write pulse length wrong");
  a_init_all_flags: assert property (@(posedge clk) disable iff (!nrst) $rose(init_done) |-> init_wr_cnt_r == INIT_WRITES)
    else $error("initialisation missed a flag");
  a_release_clears: assert property (@(posedge clk) disable iff (!nrst) rsp_valid && op_r == OP_RELEASE |-> !owned[rsp_flag] && !pending[rsp_flag] && !rsp_granted)
    else $error("release left flag owned or pending");
  a_rsp_one_pulse: assert property (@(posedge clk) disable iff (!nrst) rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");

  c_claim_won: cover property (@(posedge clk) disable iff (!nrst) rsp_valid && rsp_granted && op_r == OP_CLAIM);
  c_claim_lost: cover property (@(posedge clk) disable iff (!nrst) rsp_valid && !rsp_granted && op_r == OP_CLAIM);
  c_poll_won: cover property (@(posedge clk) disable iff (!nrst) rsp_valid && rsp_granted && op_r == OP_POLL);
  c_release: cover property (@(posedge clk) disable iff (!nrst) rsp_valid && op_r == OP_RELEASE);

endmodule : dpsf_host

// ==== dpsf_sem_model.sv ====
`timescale 1ns/1ps
module dpsf_sem_model
  import dpsf_pkg::*;
(
  // Host side pins
  input  wire logic              sel_n,
  input  wire logic              ce_n,
  input  wire logic              rw_n,
  input  wire logic              oe_n,
  input  wire logic [IDX_W-1:0]  idx,
  input  wire logic [DATA_W-1:0] din,
  // Data returned to the host
  output logic      [DATA_W-1:0] dout
);
  // --------------------------------------------------------------------------
  // Request latches and ownership
  // --------------------------------------------------------------------------
  // eight latches, no init
  logic [FLAG_COUNT-1:0] req_l    = 8'hA5;
  logic [FLAG_COUNT-1:0] req_r    = 8'h3C;
  logic [FLAG_COUNT-1:0] own_l    = '0;
  logic [FLAG_COUNT-1:0] own_r    = '0;
  logic [DATA_W-1:0]     lat_r    = '0;
  int                    wr_count = 0;

  task automatic settle(input int i);
    if (own_l[i] && req_l[i]) begin
      own_l[i] = 1'b0;
      own_r[i] = ~req_r[i];
    end
    if (own_r[i] && req_r[i]) begin
      own_r[i] = 1'b0;
      own_l[i] = ~req_l[i];
    end
    if (!own_l[i] && !own_r[i]) begin
      own_l[i] = ~req_l[i];
      own_r[i] = req_l[i] & ~req_r[i];
    end
  endtask : settle

  task automatic right_write(input int i, input logic v);
    req_r[i] = v;
    settle(i);
  endtask : right_write

  initial begin
    for (int i = 0; i < FLAG_COUNT; i++) begin
      settle(i);
    end
  end

  always @(posedge rw_n) begin
    if (sel_n === 1'b0 && ce_n === 1'b1) begin
      req_l[idx] = din[0];
      settle(int'(idx));
      wr_count++;
    end
  end

  always @(negedge (sel_n | oe_n)) begin
    lat_r = {DATA_W{~own_l[idx]}};
  end

  // no stall; a released bus shows the inverse of the last value.
  assign dout = (sel_n === 1'b0 && oe_n === 1'b0) ? lat_r : ~lat_r;
endmodule : dpsf_sem_model

// ==== dpsf_host_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module dpsf_host_tb
  import dpsf_pkg::*;
;
  // --------------------------------------------------------------------------
  // Design, device model and clock
  // --------------------------------------------------------------------------
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  cmd_valid = 1'b0;
  logic [1:0]            cmd_op = 2'h0;
  logic [IDX_W-1:0]      cmd_flag = 3'h0;
  logic                  cmd_ready, rsp_valid, rsp_granted, rsp_mixed, init_done;
  logic [IDX_W-1:0]      rsp_flag, idx;
  logic [FLAG_COUNT-1:0] owned, pending;
  logic                  sel_n, ce_n, rw_n, oe_n, data_oe;
  logic [DATA_W-1:0]     data_o, data_i;
  int                    bad_count = 0;
  int                    check_count = 0;
  int                    lat;

  always #50 clk = ~clk;

  dpsf_host i_dut (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_flag(cmd_flag), .rsp_valid(rsp_valid),
    .rsp_granted(rsp_granted), .rsp_mixed(rsp_mixed), .rsp_flag(rsp_flag),
    .init_done(init_done), .owned(owned), .pending(pending),
    .token_space_select_n(sel_n), .mem_chip_enable_n(ce_n), .rw_n(rw_n),
    .oe_n(oe_n), .flag_index_lines(idx), .data_o(data_o), .data_oe(data_oe),
    .data_i(data_i)
  );

  dpsf_sem_model i_dev (
    .sel_n(sel_n), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .idx(idx),
    .din(data_o), .dout(data_i)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------------
  // Command driver and scenarios
  // --------------------------------------------------------------------------
  // Latency counts edges from the taking edge to the response edge.
  task automatic issue(input logic [1:0] op, input int f, output int n);
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      close_out();
    end
    cmd_op = op;
    cmd_flag = IDX_W'(f);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (op != OP_INIT && rsp_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (op != OP_INIT && n >= 50) begin
      bad_count++;
      close_out();
    end
  endtask : issue

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      bad_count++;
      close_out();
    end
  endtask : wait_init

  task automatic t_init();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      i_dev.right_write(i, 1'b1);
    end
    wait_init();
    `CHK("init writes", 8, i_dev.wr_count) // one write each
    `CHK("left latches", 8'hFF, i_dev.req_l) // all released
    `CHK("free flags", 8'h00, i_dev.own_l | i_dev.own_r) // all free
    `CHK("chip enable", 1'b1, ce_n) // memory deselected
    `CHK("select idle", 1'b1, sel_n) // released between accesses
    `CHK("bus idle", 1'b0, data_oe) // data released
  endtask : t_init

  task automatic t_hand_over();
    issue(OP_CLAIM, 5, lat);
    `CHK("claim latency", 12, lat) // no wait states
    `CHK("claim grant", 1'b1, rsp_granted) // write then read
    `CHK("claim flag", 3'h5, rsp_flag) // index lines
    `CHK("right view", 1'b0, i_dev.own_r[5]) // other side reads one
    i_dev.right_write(5, 1'b0);
    issue(OP_POLL, 5, lat);
    `CHK("poll latency", 7, lat) // fresh read
    `CHK("still held", 1'b1, rsp_granted) // other write ignored
    issue(OP_RELEASE, 5, lat);
    `CHK("release latency", 5, lat) // write one
    `CHK("moved right", 1'b1, i_dev.own_r[5]) // pending other wins
    `CHK("owned cleared", 1'b0, owned[5]) // released
    issue(OP_CLAIM, 5, lat);
    `CHK("lost claim", 1'b0, rsp_granted) // reads one
    `CHK("pending set", 1'b1, pending[5]) // request stays
    `CHK("left latch", 1'b0, i_dev.req_l[5]) // zero stored
    `CHK("mixed", 1'b0, rsp_mixed) // replicated bits
    i_dev.right_write(5, 1'b1);
    issue(OP_CLAIM, 5, lat);
    `CHK("pending claim latency", 7, lat) // read only
    `CHK("late grant", 1'b1, rsp_granted) // transfer on release
    `CHK("pending gone", 1'b0, pending[5]) // granted
    issue(OP_RELEASE, 5, lat);
    `CHK("free again", 1'b0, i_dev.own_l[5] | i_dev.own_r[5]) // free both
  endtask : t_hand_over

  task automatic t_all_flags();
    for (int i = 0; i < FLAG_COUNT; i++) begin
      issue(OP_CLAIM, i, lat);
      `CHK("each grant", 1'b1, rsp_granted) // independent flags
      `CHK("each flag", IDX_W'(i), rsp_flag) // index lines
    end
    `CHK("all owned", 8'hFF, owned) // eight flags
    `CHK("device owned", 8'hFF, i_dev.own_l) // first zero owns
  endtask : t_all_flags

  task automatic t_reinit();
    i_dev.right_write(3, 1'b0);
    issue(OP_INIT, 0, lat);
    `CHK("init low", 1'b0, init_done) // walk restarts
    `CHK("owned reset", 8'h00, owned) // cleared at take
    wait_init();
    `CHK("reinit writes", 28, i_dev.wr_count) // eight more writes
    `CHK("right kept 3", 8'h08, i_dev.own_r) // pending other wins
    issue(OP_POLL, 3, lat);
    `CHK("poll lost", 1'b0, rsp_granted) // poll sees one
  endtask : t_reinit

  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_init();
    t_hand_over();
    t_all_flags();
    t_reinit();
    close_out();
  end
endmodule : dpsf_host_tb
